// ---- logic/vib_pkg.sv ----
// package for the vl/isa master cycle bridge: timing counts, states, widths
// assumes one 125 mhz system clock shared by every file of the block
package vib_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned REFRESH_NS      = 15000;
  localparam int unsigned REFRESH_CYCLES  = (REFRESH_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned BURST_BEATS     = 4;
  localparam int unsigned QWORDS_FETCHED  = 4;
  localparam int unsigned SNOOP_HIST      = 4;
  localparam int unsigned TURBO_BIT       = 2;
  localparam int unsigned HOLD_SPEED_LSB  = 0;
  localparam int unsigned HOLD_SPEED_W    = 8;
  localparam int unsigned REFRESH_ADDR_W  = 8;
  localparam logic [7:0]  HOLD_SPEED_RST  = 8'h00;

  typedef enum logic [10:0] {
    VIB_IDLE    = 11'h001,
    VIB_ADDR    = 11'h002,
    VIB_SNOOP   = 11'h004,
    VIB_FETCH   = 11'h008,
    VIB_BURST   = 11'h010,
    VIB_WWAIT   = 11'h020,
    VIB_ISA_LO  = 11'h040,
    VIB_ISA_HI  = 11'h080,
    VIB_ISA_END = 11'h100,
    VIB_VLFWD   = 11'h200,
    VIB_RDYRTN  = 11'h400
  } vib_state_t;
endpackage : vib_pkg

// ---- logic/vib_snoop_filter.sv ----
// snoop filter: remembers the last few snooped dword addresses
// assumes addresses are stable in the cycle the lookup is made
`timescale 1ns/1ps
`default_nettype none
module vib_snoop_filter #(
  parameter int unsigned DEPTH = vib_pkg::SNOOP_HIST,
  parameter int unsigned AW    = 30
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic          record_i,
  output logic               hit_o
);
  logic [AW-1:0]    addr_ff  [DEPTH];
  logic [DEPTH-1:0] valid_ff;
  logic [DEPTH-1:0] match;

  for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
    assign match[g] = valid_ff[g] && (addr_ff[g] == addr_i);
  end
  assign hit_o = |match;

  // history starts empty; oldest entry falls out
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_ff <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        addr_ff[i] <= '0;
      end
    end else if (record_i) begin
      valid_ff <= {valid_ff[DEPTH-2:0], 1'b1};
      addr_ff[0] <= addr_i;
      for (int i = 1; i < DEPTH; i++) begin
        addr_ff[i] <= addr_ff[i-1];
      end
    end
  end
endmodule // vib_snoop_filter
`default_nettype wire

// ---- logic/vib_bridge.sv ----
// vl/isa master cycle bridge: vl master reads, isa translation, isa hold,
// isa master forwarding, refresh and turbo slow-down
// assumes all inputs synchronous to clk_sys_i; strobes are active low
`timescale 1ns/1ps
`default_nettype none
module vib_bridge #(
  parameter int unsigned REFRESH_CNT = vib_pkg::REFRESH_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        refresh_en_i,
  input  wire logic [7:0]  sys_ctrl_port_i,
  input  wire logic [31:0] main_config_word_i,
  input  wire logic        vl_req_n_i,
  input  wire logic        vl_ads_n_i,
  input  wire logic [31:2] vl_addr_i,
  input  wire logic        vl_mem_i,
  input  wire logic        vl_write_i,
  input  wire logic        vl_blast_n_i,
  input  wire logic        vl_dev_n_i,
  input  wire logic        vl_rdy_n_i,
  input  wire logic [31:0] vl_data_i,
  input  wire logic        in_main_mem_i,
  input  wire logic        hi_prio_req_i,
  input  wire logic        snoop_done_i,
  input  wire logic [63:0] dram_data_bus_i,
  input  wire logic        isa_hold_request_i,
  input  wire logic        isa_memr_n_i,
  input  wire logic        isa_memw_n_i,
  input  wire logic        isa_ior_n_i,
  input  wire logic        isa_iochrdy_i,
  input  wire logic        isa_refresh_n_i,
  output logic             cpu_grant_n_o,
  output logic             vl_grant_n_o,
  output logic             vl_brdy_n_o,
  output logic             vl_lrdy_n_o,
  output logic             vl_ads_n_o,
  output logic             vl_mem_o,
  output logic [3:0]       vl_be_n_o,
  output logic [31:0]      vl_data_o,
  output logic             vl_rdyrtn_n_o,
  output logic             snoop_req_o,
  output logic [31:2]      snoop_addr_o,
  output logic             dram_column_strobe_n_o,
  output logic [10:0]      dram_row_col_address_o,
  output logic             isa_hold_acknowledge_o,
  output logic             isa_bale_o,
  output logic             isa_sbhe_n_o,
  output logic [1:0]       isa_sa_lo_o,
  output logic             isa_iow_n_o,
  output logic             isa_ior_n_o,
  output logic             isa_memr_n_o,
  output logic             isa_refresh_n_o,
  output logic [7:0]       isa_refresh_addr_o,
  output logic             isa_iochrdy_oe_o,
  output logic             isa_memcs16_n_o,
  output logic [15:0]      isa_data_o
);
  vib_pkg::vib_state_t st_ff;
  logic [1:0]   beat_ff;
  logic [2:0]   qw_ff;
  logic [63:0]  q_ff [vib_pkg::QWORDS_FETCHED];
  logic         q_valid_ff;
  logic [31:5]  q_tag_ff;
  logic [31:2]  addr_ff;
  logic         blast_ff;
  logic         snp_hit;
  logic         q_hit;
  logic         isa_mst_ff;
  logic         snp_busy_ff;
  logic         rdy_d_ff;
  logic         rfsh_en_ff;
  logic [31:0]  rfsh_tmr_ff;
  logic [7:0]   stretch_ff;
  logic         rfsh_act_ff;
  logic         isa_cyc;
  logic         isa_cyc_d_ff;
  logic         isa_io_ff;

  vib_snoop_filter #(.DEPTH(vib_pkg::SNOOP_HIST), .AW(30)) u_snf (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .addr_i    (addr_ff),
    .record_i  (snoop_req_o),
    .hit_o     (snp_hit)
  );

  assign q_hit   = q_valid_ff && (q_tag_ff == addr_ff[31:5]);
  assign isa_cyc = !(isa_memr_n_i && isa_memw_n_i && isa_ior_n_i);

  // vl master transaction sequencer
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= vib_pkg::VIB_IDLE;
      beat_ff <= 2'h0;
      qw_ff <= 3'h0;
      addr_ff <= '0;
      blast_ff <= 1'b1;
      q_valid_ff <= 1'b0;
      q_tag_ff <= '0;
      vl_brdy_n_o <= 1'b1;
      vl_lrdy_n_o <= 1'b1;
      vl_data_o <= 32'h0;
      snoop_req_o <= 1'b0;
      snoop_addr_o <= '0;
      snp_busy_ff <= 1'b0;
      dram_column_strobe_n_o <= 1'b1;
      dram_row_col_address_o <= 11'h000;
      isa_bale_o <= 1'b0;
      isa_sbhe_n_o <= 1'b1;
      isa_sa_lo_o <= 2'h0;
      isa_iow_n_o <= 1'b1;
      isa_ior_n_o <= 1'b1;
      isa_data_o <= 16'h0;
      for (int i = 0; i < vib_pkg::QWORDS_FETCHED; i++) begin
        q_ff[i] <= 64'h0;
      end
    end else begin
      vl_brdy_n_o <= 1'b1;
      vl_lrdy_n_o <= 1'b1;
      snoop_req_o <= 1'b0;
      dram_column_strobe_n_o <= 1'b1;
      // latch enable one clock behind acknowledge
      isa_bale_o <= isa_hold_acknowledge_o;
      case (st_ff)
        vib_pkg::VIB_IDLE: begin
          if (!vl_grant_n_o && !vl_ads_n_i) begin
            st_ff <= vib_pkg::VIB_ADDR;
          end else if (isa_hold_acknowledge_o && isa_cyc && !isa_cyc_d_ff && in_main_mem_i) begin
            // isa master access to main memory is snooped as well
            addr_ff <= vl_addr_i;
            st_ff <= vib_pkg::VIB_SNOOP;
          end
        end
        vib_pkg::VIB_ADDR: begin
          // latch address and burst-last after strobe
          addr_ff <= vl_addr_i;
          blast_ff <= vl_blast_n_i;
          beat_ff <= 2'h0;
          if (!in_main_mem_i) begin
            // translate to isa; only low address bits
            st_ff <= vib_pkg::VIB_ISA_LO;
            isa_sa_lo_o <= 2'h0;
            isa_bale_o <= 1'b1;
            isa_sbhe_n_o <= 1'b0;
          end else begin
            st_ff <= vib_pkg::VIB_SNOOP;
          end
        end
        vib_pkg::VIB_SNOOP: begin
          // skip on history hit; read-to-own snoop otherwise
          if (!snp_hit && !snp_busy_ff) begin
            snoop_req_o <= 1'b1;
            snoop_addr_o <= addr_ff;
            snp_busy_ff <= 1'b1;
          end else if (!snp_busy_ff || snoop_done_i) begin
            // history records at issue, so an issued snoop waits for its answer
            snp_busy_ff <= 1'b0;
            if (isa_mst_ff) begin
              st_ff <= vib_pkg::VIB_IDLE;
            end else if (vl_write_i) begin
              st_ff <= vib_pkg::VIB_WWAIT;
            end else if (q_hit) begin
              st_ff <= vib_pkg::VIB_BURST;
            end else begin
              st_ff <= vib_pkg::VIB_FETCH;
              qw_ff <= 3'h0;
              q_valid_ff <= 1'b0;
            end
          end
        end
        vib_pkg::VIB_FETCH: begin
          // one column strobe per qword, ready held off
          dram_row_col_address_o <= {addr_ff[13:5], qw_ff[1:0]};
          if (qw_ff != 3'(vib_pkg::QWORDS_FETCHED)) begin
            dram_column_strobe_n_o <= 1'b0;
            qw_ff <= qw_ff + 3'h1;
          end
          if (!dram_column_strobe_n_o) begin
            q_ff[2'(qw_ff - 3'h1)] <= dram_data_bus_i;
            // all four qwords held as prefetch
            if (qw_ff == 3'(vib_pkg::QWORDS_FETCHED)) begin
              q_valid_ff <= 1'b1;
              q_tag_ff <= addr_ff[31:5];
              st_ff <= vib_pkg::VIB_BURST;
            end
          end
        end
        vib_pkg::VIB_BURST: begin
          // burst ready stays low for all beats; two qwords returned
          vl_brdy_n_o <= 1'b0;
          vl_data_o <= beat_ff[0] ? q_ff[{addr_ff[4], beat_ff[1]}][63:32]
                                  : q_ff[{addr_ff[4], beat_ff[1]}][31:0];
          beat_ff <= beat_ff + 2'h1;
          if (beat_ff == 2'(vib_pkg::BURST_BEATS - 1)) begin
            st_ff <= vib_pkg::VIB_IDLE;
          end
        end
        vib_pkg::VIB_WWAIT: begin
          // extra wait picks local or burst ready
          if (blast_ff) begin
            vl_brdy_n_o <= 1'b0;
          end else begin
            vl_lrdy_n_o <= 1'b0;
          end
          st_ff <= vib_pkg::VIB_IDLE;
        end
        vib_pkg::VIB_ISA_LO: begin
          // first word, io write or io read
          isa_iow_n_o <= !vl_write_i;
          isa_ior_n_o <= vl_write_i;
          isa_data_o <= vl_data_i[15:0];
          if (!isa_iow_n_o || !isa_ior_n_o) begin
            isa_iow_n_o <= 1'b1;
            isa_ior_n_o <= 1'b1;
            vl_data_o[15:0] <= vl_data_i[15:0];
            isa_sa_lo_o <= 2'h2;
            isa_bale_o <= 1'b1;
            st_ff <= vib_pkg::VIB_ISA_HI;
          end
        end
        vib_pkg::VIB_ISA_HI: begin
          // second word with its own latch pulse
          isa_iow_n_o <= !vl_write_i;
          isa_ior_n_o <= vl_write_i;
          isa_data_o <= vl_data_i[31:16];
          if (!isa_iow_n_o || !isa_ior_n_o) begin
            isa_iow_n_o <= 1'b1;
            isa_ior_n_o <= 1'b1;
            vl_data_o[31:16] <= vl_data_i[15:0];
            st_ff <= vib_pkg::VIB_ISA_END;
          end
        end
        vib_pkg::VIB_ISA_END: begin
          // ready back to the vl master
          vl_lrdy_n_o <= 1'b0;
          isa_sbhe_n_o <= 1'b1;
          st_ff <= vib_pkg::VIB_IDLE;
        end
        default: begin
          st_ff <= vib_pkg::VIB_IDLE;
        end
      endcase
      // vl slave io read data onto isa the clock after ready
      if (isa_mst_ff && isa_io_ff && !vl_rdy_n_i) begin
        isa_data_o <= vl_data_i[15:0];
      end
      if (rfsh_act_ff) begin
        isa_sa_lo_o <= isa_refresh_addr_o[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_grant_n_o <= 1'b0;
      vl_grant_n_o <= 1'b1;
      isa_hold_acknowledge_o <= 1'b0;
    end else begin
      if (isa_hold_request_i && vl_grant_n_o && !hi_prio_req_i) begin
        cpu_grant_n_o <= 1'b1;
        isa_hold_acknowledge_o <= cpu_grant_n_o;
      end else if (!isa_hold_request_i && isa_hold_acknowledge_o) begin
        isa_hold_acknowledge_o <= 1'b0;
        cpu_grant_n_o <= 1'b0;
      end else if (!vl_req_n_i && !isa_hold_acknowledge_o) begin
        cpu_grant_n_o <= 1'b1;
        vl_grant_n_o <= !cpu_grant_n_o;
      end else if (vl_req_n_i && !vl_grant_n_o) begin
        vl_grant_n_o <= 1'b1;
      end else if (vl_grant_n_o && !isa_hold_acknowledge_o) begin
        cpu_grant_n_o <= 1'b0;
      end
    end
  end

  // isa master cycles towards main memory or the vl bus
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      isa_mst_ff <= 1'b0;
      isa_cyc_d_ff <= 1'b0;
      rdy_d_ff <= 1'b0;
      isa_io_ff <= 1'b0;
      isa_iochrdy_oe_o <= 1'b0;
      isa_memcs16_n_o <= 1'b1;
      vl_ads_n_o <= 1'b1;
      vl_mem_o <= 1'b1;
      vl_be_n_o <= 4'hf;
      vl_rdyrtn_n_o <= 1'b1;
    end else begin
      isa_cyc_d_ff <= isa_cyc;
      rdy_d_ff <= isa_mst_ff && !vl_rdy_n_i;
      vl_ads_n_o <= 1'b1;
      vl_rdyrtn_n_o <= 1'b1;
      // chip select for a claiming vl memory slave
      isa_memcs16_n_o <= !(isa_hold_acknowledge_o && !in_main_mem_i && !vl_dev_n_i);
      if (isa_hold_acknowledge_o && isa_cyc && !isa_cyc_d_ff) begin
        isa_mst_ff <= 1'b1;
        isa_io_ff <= !isa_ior_n_i;
        // wait states while snooping main memory
        if (in_main_mem_i) begin
          isa_iochrdy_oe_o <= 1'b1;
        end else if (!vl_dev_n_i) begin
          isa_iochrdy_oe_o <= 1'b1;
          vl_ads_n_o <= 1'b0;
          vl_mem_o <= isa_ior_n_i;
          vl_be_n_o <= isa_ior_n_i ? 4'hc : 4'he;
        end
      end else if (isa_mst_ff && in_main_mem_i && st_ff == vib_pkg::VIB_IDLE) begin
        // snoop answered or skipped: sequencer is back in idle
        isa_iochrdy_oe_o <= 1'b0;
      end else if (rdy_d_ff) begin
        // data to isa next clock on io reads, ready one later
        isa_iochrdy_oe_o <= 1'b0;
      end
      if (isa_mst_ff && !isa_cyc) begin
        isa_mst_ff <= 1'b0;
        isa_iochrdy_oe_o <= 1'b0;
        vl_rdyrtn_n_o <= !isa_io_ff;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rfsh_en_ff <= 1'b0;
      rfsh_tmr_ff <= 32'h0;
      rfsh_act_ff <= 1'b0;
      stretch_ff <= vib_pkg::HOLD_SPEED_RST;
      isa_refresh_n_o <= 1'b1;
      isa_memr_n_o <= 1'b1;
      isa_refresh_addr_o <= 8'h00;
    end else begin
      rfsh_en_ff <= refresh_en_i;
      rfsh_tmr_ff <= (rfsh_tmr_ff >= 32'(REFRESH_CNT - 1)) ? 32'h0 : rfsh_tmr_ff + 32'h1;
      if (!rfsh_act_ff && ((rfsh_en_ff && rfsh_tmr_ff == 32'h0) || !isa_refresh_n_i)) begin
        rfsh_act_ff <= 1'b1;
        isa_refresh_n_o <= !isa_refresh_n_i ? 1'b1 : 1'b0;
        isa_memr_n_o <= 1'b0;
        stretch_ff <= sys_ctrl_port_i[vib_pkg::TURBO_BIT] ? 8'h00 :
                      main_config_word_i[vib_pkg::HOLD_SPEED_LSB +: vib_pkg::HOLD_SPEED_W];
      end else if (rfsh_act_ff && isa_iochrdy_i) begin
        if (stretch_ff != 8'h00) begin
          stretch_ff <= stretch_ff - 8'h01;
        end else begin
          rfsh_act_ff <= 1'b0;
          isa_refresh_n_o <= 1'b1;
          isa_memr_n_o <= 1'b1;
          isa_refresh_addr_o <= isa_refresh_addr_o + 8'h01;
        end
      end
    end
  end
endmodule // vib_bridge
`default_nettype wire

// ---- test/vib_properties.sv ----
// checker: timing relations seen at the bridge ports
// assumes bind onto vib_bridge; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module vib_properties #(
  parameter int unsigned REFRESH_CNT = 20
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic hi_prio_req_i,
  input wire logic isa_hold_request_i,
  input wire logic in_main_mem_i,
  input wire logic isa_memw_n_i,
  input wire logic isa_memr_n_i,
  input wire logic isa_ior_n_i,
  input wire logic isa_iochrdy_i,
  input wire logic vl_write_i,
  input wire logic cpu_grant_n_o,
  input wire logic vl_grant_n_o,
  input wire logic vl_brdy_n_o,
  input wire logic vl_rdyrtn_n_o,
  input wire logic dram_column_strobe_n_o,
  input wire logic isa_hold_acknowledge_o,
  input wire logic isa_bale_o,
  input wire logic isa_sbhe_n_o,
  input wire logic isa_iow_n_o,
  input wire logic isa_iochrdy_oe_o,
  input wire logic isa_memr_n_o,
  input wire logic isa_refresh_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_hold_grab;
    cpu_grant_n_o ##1 isa_hold_acknowledge_o ##1 isa_bale_o;
  endsequence
  sequence s_hold_free;
    (!isa_hold_acknowledge_o && !cpu_grant_n_o) ##1 !isa_bale_o;
  endsequence
  property p_vl_grant;
    $fell(vl_grant_n_o) |-> $past(cpu_grant_n_o) && !$past(cpu_grant_n_o, 2);
  endproperty
  property p_hold_grab;
    isa_hold_request_i && !isa_hold_acknowledge_o && !cpu_grant_n_o && vl_grant_n_o
      && !hi_prio_req_i |=> s_hold_grab;
  endproperty
  property p_hold_free;
    $fell(isa_hold_request_i) && isa_hold_acknowledge_o |=> s_hold_free;
  endproperty
  property p_chrdy_wait;
    ($fell(isa_memw_n_i) || $fell(isa_memr_n_i)) && isa_hold_acknowledge_o && in_main_mem_i
      |=> isa_iochrdy_oe_o;
  endproperty
  property p_burst;
    $fell(vl_brdy_n_o) && !vl_write_i |-> !vl_brdy_n_o [*4] ##1 vl_brdy_n_o;
  endproperty
  property p_miss_hold;
    !dram_column_strobe_n_o |-> vl_brdy_n_o;
  endproperty
  property p_split;
    $fell(isa_iow_n_o) |-> !isa_sbhe_n_o ##1 isa_iow_n_o;
  endproperty
  property p_rdyrtn;
    $fell(vl_rdyrtn_n_o) |-> isa_ior_n_i ##1 vl_rdyrtn_n_o;
  endproperty
  property p_refresh;
    !isa_refresh_n_o && !isa_memr_n_o && !isa_iochrdy_i |=> !isa_memr_n_o;
  endproperty
  a_vl_grant: assert property (p_vl_grant)
    else $error("vl grant not one clock after cpu grant drop");
  a_hold_grab: assert property (p_hold_grab)
    else $error("hold grant order wrong");
  a_hold_free: assert property (p_hold_free)
    else $error("hold release order wrong");
  a_chrdy_wait: assert property (p_chrdy_wait)
    else $error("channel ready not pulled low");
  a_burst: assert property (p_burst)
    else $error("burst ready not four cycles");
  a_miss_hold: assert property (p_miss_hold)
    else $error("burst ready during fetch");
  a_split: assert property (p_split)
    else $error("isa write word without byte-high");
  a_rdyrtn: assert property (p_rdyrtn)
    else $error("ready return not one clock");
  a_refresh: assert property (p_refresh)
    else $error("refresh not lengthened");
endmodule // vib_properties
`default_nettype wire

// ---- test/vib_partner.sv ----
// partner: cpu snoop answer, vl slave ready, dram data, channel-ready wire
// assumes all bridge outputs change on the rising edge of clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module vib_partner (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        slow_i,
  input  wire logic        ext_wait_i,
  input  wire logic        snp_req_i,
  input  wire logic        ads_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        chrdy_oe_i,
  output logic             snp_done_o,
  output logic             rdy_n_o,
  output logic             chrdy_o,
  output logic [63:0]      mdata_o
);
  logic [2:0]  snp_cnt_ff;
  logic [2:0]  rdy_cnt_ff;
  logic [1:0]  qw_ff;
  logic [63:0] qw;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) snp_cnt_ff <= 3'h0;
    else if (snp_req_i) snp_cnt_ff <= slow_i ? 3'h4 : 3'h1;
    else if (snp_cnt_ff != 3'h0) snp_cnt_ff <= snp_cnt_ff - 3'h1;
  end
  assign snp_done_o = (snp_cnt_ff == 3'h1);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) rdy_cnt_ff <= 3'h0;
    else if (!ads_n_i) rdy_cnt_ff <= slow_i ? 3'h3 : 3'h1;
    else if (rdy_cnt_ff != 3'h0) rdy_cnt_ff <= rdy_cnt_ff - 3'h1;
  end
  assign rdy_n_o = (rdy_cnt_ff != 3'h1);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) qw_ff <= 2'h0;
    else if (!cas_n_i) qw_ff <= qw_ff + 2'h1;
  end
  assign qw = {28'hc0de000, 1'b0, qw_ff, 1'b1, 28'hc0de000, 1'b0, qw_ff, 1'b0};
  // released data bus must not look valid, so it shows the inverse
  assign mdata_o = cas_n_i ? ~qw : qw;
  // pulled-up wire, any party may hold it low
  assign chrdy_o = ~(chrdy_oe_i | ext_wait_i);
endmodule // vib_partner
`default_nettype wire

// ---- test/testbench.sv ----
// testbench: drives the bridge as vl master, isa master and refresh user
// assumes vib_pkg and vib_partner compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned REF = 20;
  logic clk_sys_i = 1'b0, rst_b_i = 1'b0, refresh_en_i = 1'b0, hi_prio_req_i = 1'b0;
  logic vl_req_n_i = 1'b1, vl_ads_n_i = 1'b1, vl_blast_n_i = 1'b1, vl_dev_n_i = 1'b1;
  logic vl_mem_i = 1'b1, in_main_mem_i = 1'b1, vl_write_i = 1'b0, isa_hold_request_i = 1'b0;
  logic isa_memr_n_i = 1'b1, isa_memw_n_i = 1'b1, isa_ior_n_i = 1'b1, isa_refresh_n_i = 1'b1;
  logic slow = 1'b0, slave_wait = 1'b0, vl_rdy_n_i, snoop_done_i, isa_iochrdy_i;
  logic [7:0]  sys_ctrl_port_i = 8'h04;
  logic [31:0] main_config_word_i = 32'h0, vl_data_i = 32'h0;
  logic [31:2] vl_addr_i = 30'h0;
  logic [63:0] dram_data_bus_i;
  logic cpu_grant_n_o, vl_grant_n_o, vl_brdy_n_o, vl_lrdy_n_o, vl_ads_n_o, vl_mem_o;
  logic vl_rdyrtn_n_o, snoop_req_o, dram_column_strobe_n_o, isa_hold_acknowledge_o;
  logic isa_bale_o, isa_sbhe_n_o, isa_iow_n_o, isa_ior_n_o, isa_memr_n_o, isa_refresh_n_o;
  logic isa_iochrdy_oe_o, isa_memcs16_n_o;
  logic [3:0]  vl_be_n_o;
  logic [31:0] vl_data_o;
  logic [31:2] snoop_addr_o;
  logic [10:0] dram_row_col_address_o;
  logic [1:0]  isa_sa_lo_o;
  logic [7:0]  isa_refresh_addr_o;
  logic [15:0] isa_data_o;
  int fail_count = 0;
  int n_compared = 0;
  int cy = 0;
  vib_bridge #(.REFRESH_CNT(REF)) i_dut (.*);
  vib_partner i_partner (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .slow_i     (slow),
    .ext_wait_i (slave_wait),
    .snp_req_i  (snoop_req_o),
    .ads_n_i    (vl_ads_n_o),
    .cas_n_i    (dram_column_strobe_n_o),
    .chrdy_oe_i (isa_iochrdy_oe_o),
    .snp_done_o (snoop_done_i),
    .rdy_n_o    (vl_rdy_n_i),
    .chrdy_o    (isa_iochrdy_i),
    .mdata_o    (dram_data_bus_i)
  );
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cy <= cy + 1;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bounded wait, so a silent design ends as a mismatch, not a hang
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 300 && s !== v; i++) @(posedge clk_sys_i);
    chk("wait", 32'(s), 32'(v));
  endtask
  task automatic t_reset();
    int r = 0;
    chk("cpu grant", 32'(cpu_grant_n_o), 32'h0);
    repeat (3 * REF) begin
      @(posedge clk_sys_i);
      r += !isa_refresh_n_o;
    end
    chk("refresh off", r, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_read(input logic miss);
    int sn = 0, cs = 0, b = 0;
    vl_req_n_i <= 1'b0;
    wt(vl_grant_n_o, 1'b0);
    vl_ads_n_i <= 1'b0;
    vl_addr_i <= 30'h100;
    @(posedge clk_sys_i);
    vl_ads_n_i <= 1'b1;
    for (int i = 0; i < 80 && b < 4; i++) begin
      @(posedge clk_sys_i);
      sn += snoop_req_o;
      cs += !dram_column_strobe_n_o;
      if (!dram_column_strobe_n_o) chk("column", 32'(dram_row_col_address_o), 32'h7f + cs);
      if (snoop_req_o) chk("snoop addr", 32'(snoop_addr_o), 32'h100);
      if (!vl_brdy_n_o) begin
        chk("beat data", vl_data_o, 32'hc0de_0000 + b);
        b++;
        vl_addr_i <= vl_addr_i + 30'h1;
      end
      vl_blast_n_i <= (b != 3);
    end
    vl_blast_n_i <= 1'b1;
    vl_req_n_i <= 1'b1;
    chk("beats", b, 32'h4);
    chk("snoops", sn, 32'(miss));
    chk("strobes", cs, miss ? 32'h4 : 32'h0);
    wt(vl_grant_n_o, 1'b1);
    $display("memory read test done");
  endtask
  task automatic t_wr();
    vl_req_n_i <= 1'b0;
    wt(vl_grant_n_o, 1'b0);
    vl_write_i <= 1'b1;
    vl_blast_n_i <= 1'b0;
    vl_ads_n_i <= 1'b0;
    @(posedge clk_sys_i);
    vl_ads_n_i <= 1'b1;
    wt(vl_lrdy_n_o, 1'b0);
    chk("single brdy", 32'(vl_brdy_n_o), 32'h1);
    vl_req_n_i <= 1'b1;
    vl_write_i <= 1'b0;
    vl_blast_n_i <= 1'b1;
    wt(vl_grant_n_o, 1'b1);
    $display("memory write test done");
  endtask
  task automatic t_xlat(input logic wr);
    int n = 0, ba = 0, bad = 0;
    logic pb = 1'b0;
    vl_req_n_i <= 1'b0;
    wt(vl_grant_n_o, 1'b0);
    in_main_mem_i <= 1'b0;
    vl_write_i <= wr;
    vl_blast_n_i <= 1'b0;
    vl_data_i <= 32'hdead_beef;
    vl_ads_n_i <= 1'b0;
    @(posedge clk_sys_i);
    vl_ads_n_i <= 1'b1;
    for (int i = 0; i < 80 && vl_lrdy_n_o; i++) begin
      @(posedge clk_sys_i);
      ba += isa_bale_o && !pb;
      pb = isa_bale_o;
      bad += wr ? !isa_ior_n_o : !isa_iow_n_o;
      if (!(wr ? isa_iow_n_o : isa_ior_n_o)) begin
        chk("sa low", 32'(isa_sa_lo_o), {30'h0, n[0], 1'b0});
        if (wr) chk("sd", 32'(isa_data_o), n ? 32'hdead : 32'hbeef);
        n++;
      end
    end
    vl_req_n_i <= 1'b1;
    vl_write_i <= 1'b0;
    chk("lrdy", 32'(vl_lrdy_n_o), 32'h0);
    chk("words", n, 32'h2);
    chk("latch pulses", ba, 32'h2);
    chk("wrong strobe", bad, 32'h0);
    if (!wr) chk("read data", vl_data_o, 32'hbeef_beef);
    wt(vl_grant_n_o, 1'b1);
    $display("isa translation test done");
  endtask
  task automatic t_isa();
    int sn = 0, oe = 0, v = 0;
    hi_prio_req_i <= 1'b1;
    isa_hold_request_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("hold deferred", 32'(cpu_grant_n_o), 32'h0);
    hi_prio_req_i <= 1'b0;
    wt(isa_bale_o, 1'b1);
    in_main_mem_i <= 1'b1;
    vl_addr_i <= 30'h340;
    isa_memr_n_i <= 1'b0;
    repeat (30) begin
      @(posedge clk_sys_i);
      sn += snoop_req_o;
      oe += isa_iochrdy_oe_o;
    end
    chk("isa snoop", sn, 32'h1);
    chk("wait states", 32'(oe > 0), 32'h1);
    chk("chrdy freed", 32'(isa_iochrdy_oe_o), 32'h0);
    isa_memr_n_i <= 1'b1;
    in_main_mem_i <= 1'b0;
    vl_dev_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("cs16", 32'(isa_memcs16_n_o), 32'h0);
    isa_memw_n_i <= 1'b0;
    wt(vl_ads_n_o, 1'b0);
    chk("mem be", {27'h0, vl_mem_o, vl_be_n_o}, 32'h1c);
    @(posedge clk_sys_i);
    wt(isa_iochrdy_oe_o, 1'b0);
    isa_memw_n_i <= 1'b1;
    vl_data_i <= 32'h0000_5a3c;
    @(posedge clk_sys_i);
    isa_ior_n_i <= 1'b0;
    wt(vl_ads_n_o, 1'b0);
    chk("io be", {27'h0, vl_mem_o, vl_be_n_o}, 32'h0e);
    @(posedge clk_sys_i);
    wt(isa_iochrdy_oe_o, 1'b0);
    chk("io data", 32'(isa_data_o), 32'h5a3c);
    isa_ior_n_i <= 1'b1;
    wt(vl_rdyrtn_n_o, 1'b0);
    vl_dev_n_i <= 1'b1;
    isa_memw_n_i <= 1'b0;
    repeat (20) begin
      @(posedge clk_sys_i);
      v += !vl_ads_n_o;
      v += isa_iochrdy_oe_o;
    end
    chk("ignored", v, 32'h0);
    isa_memw_n_i <= 1'b1;
    isa_hold_request_i <= 1'b0;
    wt(cpu_grant_n_o, 1'b0);
    $display("isa master test done");
  endtask
  task automatic rf(output int t, output logic [7:0] a, output int d);
    wt(isa_refresh_n_o, 1'b0);
    t = cy;
    a = isa_refresh_addr_o;
    d = 0;
    slave_wait <= 1'b1;
    while (!isa_refresh_n_o && d < 900) begin
      @(posedge clk_sys_i);
      d++;
      if (d == 3) slave_wait <= 1'b0;
    end
  endtask
  task automatic t_refresh();
    int t0, t1, d1, d2;
    logic [7:0] a0, a1;
    refresh_en_i <= 1'b1;
    rf(t0, a0, d1);
    rf(t1, a1, d1);
    chk("period", t1 - t0, REF);
    chk("row step", 32'(a1), 32'(a0 + 8'h1));
    sys_ctrl_port_i <= 8'h00;
    main_config_word_i <= 32'h0000_0010;
    rf(t0, a0, d2);
    rf(t0, a0, d2);
    chk("stretch", 32'(d2 > d1), 32'h1);
    refresh_en_i <= 1'b0;
    isa_refresh_n_i <= 1'b0;
    wt(isa_memr_n_o, 1'b0);
    a0 = isa_refresh_addr_o;
    isa_refresh_n_i <= 1'b1;
    wt(isa_memr_n_o, 1'b1);
    chk("ext refresh row", 32'(isa_refresh_addr_o), 32'(a0 + 8'h1));
    $display("refresh test done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_read(1'b1);
    t_read(1'b0);
    t_wr();
    t_xlat(1'b1);
    t_xlat(1'b0);
    slow <= 1'b1;
    t_isa();
    t_refresh();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    test_done();
  end
endmodule // testbench
bind vib_bridge vib_properties #(.REFRESH_CNT(REFRESH_CNT)) i_props (.*);
`default_nettype wire
